// ===== hdl/panel_io_pkg.sv
// Purpose: shared constants and carriers for the panel switch and rear pin registers
// Assumes: register numbers are the host-visible addresses on the serial register port
// Notes:   all positions, addresses and reset values live here
package panel_io_pkg;

  // register addresses as seen by the host register port
  localparam int           ADDR_W            = 8;
  localparam logic [7:0]   SWITCH_FLAGS_ADDR = 8'h97;
  localparam logic [7:0]   PIN_STATE_ADDR    = 8'h98;

  // field positions
  localparam int           REMOTE_BIT  = 15;  // front panel disable
  localparam int           EMU_BITS    = 7;   // host-emulated switch bits 0..6
  localparam int           FN3_BIT     = 7;
  localparam int           RSV_LO_BIT  = 8;
  localparam int           RSV_HI_BIT  = 14;
  localparam int           OD_PINS     = 3;   // hold, lock, capture
  localparam int           PIN_FIELDS  = 5;   // pins shown in the rear register

  // values after reset
  localparam logic [15:0]  SWITCH_RESET = 16'h0000;
  localparam logic         REMOTE_RESET = 1'b0;
  localparam logic [2:0]   DRIVE_RESET  = 3'h0;  // all pins released

  // front panel switch states, program button in bit 0
  typedef struct packed {
    logic function_button_three;
    logic function_button_two;
    logic function_button_one;
    logic lock_down;
    logic lock_up;
    logic up;
    logic down;
    logic program_button;
  } panel_switch_t;

  // rear panel pin levels, hold pin in bit 0
  typedef struct packed {
    logic general_input_two;
    logic general_input_one;
    logic capture;
    logic lock;
    logic hold;
  } rear_pin_t;

  // one host register access
  typedef struct packed {
    logic              rd_en;
    logic              wr_en;
    logic [ADDR_W-1:0] addr;
    logic [15:0]       wr_data;
  } host_req_t;

endpackage : panel_io_pkg

// ===== hdl/od_pin_bank.sv
// Purpose: open-drain drivers for the writable rear panel pins
// Assumes: a weak pull-up outside lifts a released pin
// Notes:   a stored 1 pulls the pin low, a stored 0 releases it
`timescale 1ns/1ps
module od_pin_bank #(
  parameter int N = 3
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         reset,
  // load port
  input  wire logic         load,
  input  wire logic [N-1:0] load_data,
  // pin drive
  output logic      [N-1:0] pin_out,
  output logic      [N-1:0] pin_oe_n
);

  if (N < 1) begin : g_check
    $error("od_pin_bank needs at least one pin");
  end

  // one drive flop per pin
  for (genvar i = 0; i < N; i++) begin : g_pin
    logic drive_r;
    logic drive_nxt;

    // next drive state: written value replaces the old one
    always_comb begin
      drive_nxt = drive_r;
      if (load) begin
        drive_nxt = load_data[i];
      end
    end

    // register the drive state
    always_ff @(posedge clock) begin
      if (reset) begin
        drive_r <= panel_io_pkg::DRIVE_RESET[0];
      end else begin
        drive_r <= drive_nxt;
      end
    end

    assign pin_out[i]  = 1'b0;      // only ever pulls low
    assign pin_oe_n[i] = ~drive_r;  // released when 0 was written
  end

endmodule : od_pin_bank

// ===== hdl/panel_switch_io.sv
// Purpose: front panel switch flags and rear panel pin registers of a panel meter
// Assumes: host reads and writes arrive as one-cycle strobes on the register port
// Notes:   read data appears one cycle after the read strobe
// Functional notes
// - With the front panel disable bit set, physical switches have no effect on the meter, but a switch flags read still shows function button three at bit 7.
// - In normal mode a read of the switch flags returns the live switch state; pin levels are not included.
// - Bit 7 of the switch flags reports function button three, 1 when closed.
// - Bits 8 to 14 of the switch flags are reserved and have no function.
// - The rear pin register is 16 bits and shows lock at bit 1 and capture at bit 2.
// - Bits 3 and 4 of the rear pin register show the two general inputs and are read-only.
// - A normal-mode read of the switch flags merges the switch states and the disable bit in one word.
// - Switch bits 0 to 6 are program, down, up, lock up, lock down, function one and two.
// - Rear pin reads sample the pins directly and writes drive the pins directly.
// - Writing 1 to bits 0 to 2 drives the pin low, writing 0 releases it to its pull-up.
`timescale 1ns/1ps
module panel_switch_io #(
  parameter int ADDR_W = panel_io_pkg::ADDR_W
) (
  // clock and reset
  input  wire logic                       clock,
  input  wire logic                       reset,
  // host register port
  input  wire panel_io_pkg::host_req_t    host_req,
  output logic                      [15:0] rd_data,
  output logic                             rd_valid,
  // front panel switches
  input  wire panel_io_pkg::panel_switch_t panel_switch,
  output panel_io_pkg::panel_switch_t      switch_active,
  output logic                             panel_disabled,
  // rear panel pins
  input  wire panel_io_pkg::rear_pin_t     rear_pin_in,
  output logic        [panel_io_pkg::OD_PINS-1:0] pin_out,
  output logic        [panel_io_pkg::OD_PINS-1:0] pin_oe_n
);

  if (ADDR_W != panel_io_pkg::ADDR_W) begin : g_check
    $error("panel_switch_io address width must match the package carrier");
  end

  logic                                    remote_r;
  logic                                    remote_nxt;
  logic [panel_io_pkg::EMU_BITS-1:0]       emu_r;
  logic [panel_io_pkg::EMU_BITS-1:0]       emu_nxt;
  panel_io_pkg::panel_switch_t             active_nxt;
  logic [15:0]                             rd_data_nxt;
  logic                                    rd_valid_nxt;
  logic                                    sw_wr;
  logic                                    sw_rd;
  logic                                    pin_wr;
  logic                                    pin_rd;
  logic [15:0]                             sw_view;
  logic [15:0]                             pin_view;

  // address decode
  assign sw_wr  = host_req.wr_en && (host_req.addr == panel_io_pkg::SWITCH_FLAGS_ADDR);
  assign sw_rd  = host_req.rd_en && (host_req.addr == panel_io_pkg::SWITCH_FLAGS_ADDR);
  assign pin_wr = host_req.wr_en && (host_req.addr == panel_io_pkg::PIN_STATE_ADDR);
  assign pin_rd = host_req.rd_en && (host_req.addr == panel_io_pkg::PIN_STATE_ADDR);

  // switch flag register: disable bit and emulated presses
  always_comb begin
    remote_nxt = remote_r;
    emu_nxt    = emu_r;
    if (sw_wr) begin
      remote_nxt = host_req.wr_data[panel_io_pkg::REMOTE_BIT];
      emu_nxt    = host_req.wr_data[panel_io_pkg::EMU_BITS-1:0];
    end
  end

  // switches seen by the meter: physical in normal mode, emulated when disabled
  always_comb begin
    if (remote_r) begin
      active_nxt = panel_io_pkg::panel_switch_t'({1'b0, emu_r});
    end else begin
      active_nxt = panel_switch;
    end
  end

  // read views of both registers; reserved bits stay zero
  always_comb begin
    sw_view = 16'h0000;
    sw_view[panel_io_pkg::REMOTE_BIT] = remote_r;
    if (remote_r) begin
      sw_view[panel_io_pkg::EMU_BITS-1:0] = emu_r;
    end else begin
      sw_view[panel_io_pkg::EMU_BITS-1:0] = panel_switch[panel_io_pkg::EMU_BITS-1:0];
    end
    sw_view[panel_io_pkg::FN3_BIT] = panel_switch.function_button_three;
    pin_view = 16'h0000;
    pin_view[panel_io_pkg::PIN_FIELDS-1:0] = rear_pin_in;
  end

  // read answer: one cycle after the strobe, unmapped reads give zero
  always_comb begin
    rd_valid_nxt = host_req.rd_en;
    rd_data_nxt  = 16'h0000;
    if (sw_rd) begin
      rd_data_nxt = sw_view;
    end else if (pin_rd) begin
      rd_data_nxt = pin_view;
    end
  end

  // register the switch, read and output state
  always_ff @(posedge clock) begin
    if (reset) begin
      remote_r      <= panel_io_pkg::REMOTE_RESET;
      emu_r         <= panel_io_pkg::SWITCH_RESET[panel_io_pkg::EMU_BITS-1:0];
      switch_active <= panel_io_pkg::panel_switch_t'(panel_io_pkg::SWITCH_RESET[7:0]);
      rd_data       <= 16'h0000;
      rd_valid      <= 1'b0;
    end else begin
      remote_r      <= remote_nxt;
      emu_r         <= emu_nxt;
      switch_active <= active_nxt;
      rd_data       <= rd_data_nxt;
      rd_valid      <= rd_valid_nxt;
    end
  end

  assign panel_disabled = remote_r;

  // open-drain drivers; only bits 0..2 of a write reach them
  od_pin_bank #(
    .N (panel_io_pkg::OD_PINS)
  ) u_pins (
    .clock     (clock),
    .reset     (reset),
    .load      (pin_wr),
    .load_data (host_req.wr_data[panel_io_pkg::OD_PINS-1:0]),
    .pin_out   (pin_out),
    .pin_oe_n  (pin_oe_n)
  );

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_sw_read;
    sw_rd;
  endsequence

  sequence s_pin_read;
    pin_rd;
  endsequence

  a_remote_masks_panel: assert property (
    remote_r |=> switch_active == panel_io_pkg::panel_switch_t'({1'b0, $past(emu_r)}))
    else $error("disabled panel still passes physical switches");

  a_normal_passes_panel: assert property (
    !remote_r |=> switch_active == $past(panel_switch))
    else $error("normal mode does not pass physical switches");

  a_disable_write: assert property (
    sw_wr |=> remote_r == $past(host_req.wr_data[panel_io_pkg::REMOTE_BIT]))
    else $error("disable bit did not take the written value");

  a_normal_read_live: assert property (
    s_sw_read ##0 !remote_r |=> rd_valid && rd_data[6:0] == $past(panel_switch[6:0]))
    else $error("normal read does not show live switches");

  a_func3_read: assert property (
    s_sw_read |=> rd_data[panel_io_pkg::FN3_BIT] == $past(panel_switch.function_button_three))
    else $error("function button three misreported");

  a_reserved_zero: assert property (
    s_sw_read |=> rd_data[panel_io_pkg::RSV_HI_BIT:panel_io_pkg::RSV_LO_BIT] == 7'h00)
    else $error("reserved switch bits not zero");

  a_pin_read_direct: assert property (
    s_pin_read |=> rd_valid && rd_data == {11'h000, $past(rear_pin_in)})
    else $error("rear pin read does not match pins");

  a_pin_write_drive: assert property (
    pin_wr |=> pin_oe_n == ~$past(host_req.wr_data[2:0]) && pin_out == 3'h0)
    else $error("pin drive does not follow written bits");

  a_pin_drive_hold: assert property (
    !pin_wr |=> $stable(pin_oe_n))
    else $error("pin drive changed without a write");

endmodule : panel_switch_io

// ===== bench/rear_pin_model.sv
// Purpose: rear panel wiring, open-drain pins over weak pull-ups
// Assumes: an outside contact may pull any pin low at any time
// Notes:   a pin nobody pulls low reads high
`timescale 1ns/1ps
module rear_pin_model (
  // drive from the meter
  input  wire logic [2:0]         pin_out,
  input  wire logic [2:0]         pin_oe_n,
  // outside contacts pulling low
  input  wire logic [4:0]         ext_low,
  // resolved pin levels
  output panel_io_pkg::rear_pin_t level
);
  // wired-and of every driver over the pull-up
  assign level = ~(ext_low | {2'b00, ~pin_oe_n & ~pin_out});
endmodule : rear_pin_model

// ===== bench/panel_switch_and_io_pins_test.sv
// Purpose: self-checking bench for the switch flags and rear pin registers
// Assumes: register strobes last one cycle, answers come one cycle later
// Notes:   inputs change on the falling edge only
`timescale 1ns/1ps
module panel_switch_and_io_pins_test;
  logic                        clock;
  logic                        reset;
  panel_io_pkg::host_req_t     host_req;
  logic [15:0]                 rd_data;
  logic                        rd_valid;
  panel_io_pkg::panel_switch_t panel_switch;
  panel_io_pkg::panel_switch_t switch_active;
  logic                        panel_disabled;
  panel_io_pkg::rear_pin_t     rear_pin_in;
  logic [2:0]                  pin_out;
  logic [2:0]                  pin_oe_n;
  logic [4:0]                  ext_low;
  logic [15:0]                 got;
  logic [31:0]                 w;
  logic [2:0]                  drv;
  integer                      seed;
  integer                      n_fail;
  integer                      checks;
  int                          i;

  panel_switch_io dut (.clock(clock), .reset(reset), .host_req(host_req),
    .rd_data(rd_data), .rd_valid(rd_valid), .panel_switch(panel_switch),
    .switch_active(switch_active), .panel_disabled(panel_disabled),
    .rear_pin_in(rear_pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n));
  rear_pin_model pins (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_low(ext_low),
    .level(rear_pin_in));

  // 200 MHz clock
  always #2.5 clock = ~clock;

  // compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // one-cycle strobe; the read answer is taken in the following cycle
  task automatic access(input logic rd, input logic [7:0] a, input logic [15:0] d);
    host_req = {rd, ~rd, a, d};
    @(negedge clock);
    host_req = '0;
    got = rd_data;
    if (rd) begin
      chk({15'h0000, rd_valid}, 16'h0001);
    end
    @(negedge clock);
  endtask : access

  // expected switch flags word
  function automatic logic [15:0] flags_exp(input logic dis, input logic [6:0] emu,
                                            input logic [7:0] sw);
    flags_exp = {dis, 7'h00, sw[7], dis ? emu : sw[6:0]};
  endfunction : flags_exp

  // expected rear pin word from outside pulls and our own drive
  function automatic logic [15:0] pins_exp(input logic [4:0] ext, input logic [2:0] d);
    pins_exp = {11'h000, ~(ext | {2'b00, d})};
  endfunction : pins_exp

  // verdict and end of run
  task automatic conclude();
    if (n_fail == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude

  // watchdog against a hang
  initial begin
    #20000;
    n_fail = n_fail + 1;
    conclude();
  end

  // main sequence
  initial begin
    clock = 1'b0;
    reset = 1'b1;
    host_req = '0;
    panel_switch = '0;
    ext_low = 5'h00;
    drv = 3'h0;
    seed = 64307;
    n_fail = 0;
    checks = 0;
    repeat (12) @(negedge clock);
    reset = 1'b0;
    chk({switch_active, 4'h0, panel_disabled, pin_oe_n}, 16'h0007);
    // normal mode: live switches and pins
    for (i = 0; i < 24; i++) begin
      w = $random(seed);
      panel_switch = w[7:0];
      ext_low = w[12:8];
      access(1'b1, panel_io_pkg::SWITCH_FLAGS_ADDR, 16'h0000);
      chk(got, flags_exp(1'b0, 7'h00, panel_switch));
      chk({8'h00, switch_active}, {8'h00, panel_switch});
      access(1'b1, panel_io_pkg::PIN_STATE_ADDR, 16'h0000);
      chk(got, pins_exp(ext_low, drv));
    end
    // unmapped places
    access(1'b1, 8'h99, 16'h0000);
    chk(got, 16'h0000);
    access(1'b0, 8'h96, 16'hffff);
    chk({12'h000, panel_disabled, pin_oe_n}, 16'h0007);
    // every drive pattern on the writable pins, upper bits random
    for (i = 0; i < 8; i++) begin
      w = $random(seed);
      drv = i[2:0];
      access(1'b0, panel_io_pkg::PIN_STATE_ADDR, {w[15:3], drv});
      chk({10'h000, pin_out, pin_oe_n}, {13'h0000, ~drv});
      access(1'b1, panel_io_pkg::PIN_STATE_ADDR, 16'h0000);
      chk(got, pins_exp(ext_low, drv));
    end
    drv = 3'h0;
    access(1'b0, panel_io_pkg::PIN_STATE_ADDR, 16'h0000);
    // enter disabled mode first, so no press bits are written in normal mode
    access(1'b0, panel_io_pkg::SWITCH_FLAGS_ADDR, 16'h8000);
    // panel disabled: host emulates presses, reserved bits stay zero
    for (i = 0; i < 12; i++) begin
      w = $random(seed);
      panel_switch = w[23:16];
      access(1'b0, panel_io_pkg::SWITCH_FLAGS_ADDR, {1'b1, w[14:0]});
      chk({15'h0000, panel_disabled}, 16'h0001);
      chk({8'h00, switch_active}, {9'h000, w[6:0]});
      access(1'b1, panel_io_pkg::SWITCH_FLAGS_ADDR, 16'h0000);
      chk(got, flags_exp(1'b1, w[6:0], panel_switch));
    end
    // back to normal mode
    access(1'b0, panel_io_pkg::SWITCH_FLAGS_ADDR, 16'h0000);
    chk({7'h00, panel_disabled, switch_active}, {8'h00, panel_switch});
    conclude();
  end
endmodule : panel_switch_and_io_pins_test
